/* File: hdl/dsc_core_pkg.sv */
// Constants, register map and encodings of the core register model.
package dsc_core_pkg;

  // Widths of the program side.
  localparam int unsigned PC_W      = 23;
  localparam int unsigned INSTR_W   = 24;
  localparam int unsigned PADDR_W   = 24;
  localparam int unsigned NUM_TRAPS = 8;

  // Reset values.
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] SR_RESET = 16'h0000;

  // Register byte offsets on the bus.
  localparam logic [7:0] A_STATUS  = 8'h40;
  localparam logic [7:0] A_PROGRAM_WINDOW_PAGE  = 8'h44;
  localparam logic [7:0] A_TABLE_ACCESS_PAGE  = 8'h48;
  localparam logic [7:0] A_LSTART  = 8'h4C;
  localparam logic [7:0] A_LEND    = 8'h50;
  localparam logic [7:0] A_LCOUNT  = 8'h54;
  localparam logic [7:0] A_REPEAT_ITERATION_COUNTER  = 8'h58;
  localparam logic [7:0] A_PC      = 8'h5C;
  localparam logic [7:0] A_CMD     = 8'h60;
  localparam logic [7:0] A_STACKED = 8'h64;
  localparam logic [7:0] A_EXC     = 8'h68;
  localparam logic [7:0] A_FETCH   = 8'h6C;
  localparam logic [7:0] A_PSVADDR = 8'h70;
  localparam logic [7:0] A_PSVDATA = 8'h74;
  localparam logic [7:0] A_TBLADDR = 8'h78;
  localparam logic [7:0] A_TBLDATA = 8'h7C;
  localparam logic [7:0] A_PRIO    = 8'h80;
  localparam logic [7:0] A_PRIOEND = 8'h98;
  localparam logic [7:0] A_YBASE   = 8'h9C;

  // Status word bit positions.
  localparam int unsigned SR_C   = 0;
  localparam int unsigned SR_Z   = 1;
  localparam int unsigned SR_OV  = 2;
  localparam int unsigned SR_N   = 3;
  localparam int unsigned SR_RA  = 4;
  localparam int unsigned SR_IPL = 5;
  localparam int unsigned SR_DC  = 8;
  localparam int unsigned SR_DA  = 9;
  localparam int unsigned SR_SAB = 10;
  localparam int unsigned SR_OAB = 11;
  localparam int unsigned SR_SB  = 12;
  localparam int unsigned SR_SA  = 13;
  localparam int unsigned SR_OB  = 14;
  localparam int unsigned SR_OA  = 15;
  localparam logic [15:0] SR_RO_MASK = 16'h0E10;

  // Command register fields and operation codes.
  localparam int unsigned CMD_REG = 4;
  localparam int unsigned CMD_SH  = 8;
  localparam int unsigned CMD_IMM = 16;
  localparam logic [3:0] OP_PUSHS  = 4'h1;
  localparam logic [3:0] OP_POPS   = 4'h2;
  localparam logic [3:0] OP_LOOPGO = 4'h3;
  localparam logic [3:0] OP_LOOPX  = 4'h4;
  localparam logic [3:0] OP_EXC    = 4'h5;
  localparam logic [3:0] OP_CALL   = 4'h6;
  localparam logic [3:0] OP_RET    = 4'h7;
  localparam logic [3:0] OP_SHIFT  = 4'h8;
  localparam logic [3:0] OP_BYTEWR = 4'h9;
  localparam logic [3:0] OP_STEP   = 4'hA;
  localparam logic [3:0] OP_FILEADD = 4'hB;
  localparam logic [3:0] OP_ADD3   = 4'hC;

  // Stack, shifter and exception constants.
  localparam logic [15:0] SP_STEP    = 16'h0004;
  localparam logic [5:0]  MAX_SHIFT  = 6'h10;
  localparam logic [7:0]  TRAP_USED  = 8'h1E;
  localparam logic [3:0]  TRAP_LVL   = 4'h8;
  localparam logic [2:0]  MAX_IPL    = 3'h7;
  localparam logic [21:0] PC_INC     = 22'h000002;

  // Bus slave states and bus encodings.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_DONE = 2'b11
  } bus_e;
  localparam logic [2:0] HSIZE_BYTE = 3'b000;
  localparam logic [2:0] HSIZE_HALF = 3'b001;
  localparam logic       HRESP_OKAY = 1'b0;

endpackage

/* File: hdl/dsc_core_register_model.sv */
// Programmer-visible register model of the 16-bit signal controller core.
// Summary of operation
// - Program counter is 23 bits, bit 0 zero, top bit kept on steps.
// - Instructions are 24-bit words fetched from program memory.
// - Sixteen 16-bit working registers; the last is the stack pointer.
// - Reset loads the stack pointer with its fixed start value.
// - Stack pointer bit 0 always reads and stays zero.
// - Fast save and restore copy registers 0-3 and five flags to shadows.
// - Loop start pushes loop address and count shadows; loop end pops.
// - Byte operations touch the low byte; bus byte lanes reach both bytes.
// - Exception entry stacks status low byte with upper program counter.
// - Sixty-two vectors: eight traps, four of them unused, and 54 interrupts.
// - Interrupt priority 1 to 7; ties go to the lower source number.
// - Traps have fixed priorities 8 to 15, above all interrupts.
// - Upper data half maps to program space through an 8-bit page.
// - Window reads cost one extra cycle and return the low 16 bits.
// - Table reads reach all 24 bits, paged linearly.
// - Data space split into X and Y at a fixed boundary.
// - One-stage prefetch holds the next instruction a cycle ahead.
// - Shifter moves a register up to 16 places either way in a cycle.
// - A three-operand add reads two registers and writes one per cycle.
// - Loop state survives exceptions untouched.
// - Status word: flags, priority level and loop bits as laid out.
// - Register zero is the implicit operand of file-register operations.
`timescale 1ns/1ns
module dsc_core_register_model #(
  parameter int unsigned NUM_IRQ = 54,
  parameter logic [15:0] Y_BASE  = 16'h0C00
)(
  // Clock, reset and freeze.
  input  wire  logic                             clk,
  input  wire  logic                             rstn,
  input  wire  logic                             ce,
  // AHB-Lite slave.
  input  wire  logic                             hsel,
  input  wire  logic [31:0]                      haddr,
  input  wire  logic [1:0]                       htrans,
  input  wire  logic                             hwrite,
  input  wire  logic [2:0]                       hsize,
  input  wire  logic [31:0]                      hwdata,
  output logic       [31:0]                      hrdata,
  output logic                                   hreadyout,
  output logic                                   hresp,
  // Program memory read port.
  output logic       [dsc_core_pkg::PADDR_W-1:0] progAddr,
  input  wire  logic [dsc_core_pkg::INSTR_W-1:0] progRdata,
  // Exception sources and request.
  input  wire  logic [NUM_IRQ-1:0]               irqPend,
  input  wire  logic [dsc_core_pkg::NUM_TRAPS-1:0] trapPend,
  output logic                                   excRequest
);
  import dsc_core_pkg::*;

  typedef struct packed {
    logic [15:0][15:0]      wreg;
    logic [15:0]            status;
    logic [7:0]             psvPage;
    logic [7:0]             tblPage;
    logic [PC_W-1:0]        pc;
    logic [PC_W-1:0]        loopStart;
    logic [PC_W-1:0]        loopEnd;
    logic [PC_W-1:0]        shStart;
    logic [PC_W-1:0]        shEnd;
    logic [15:0]            loopCount;
    logic [15:0]            shCount;
    logic                   shDa;
    logic [15:0]            repCount;
    logic [3:0][15:0]       shW;
    logic [4:0]             shFlags;
    logic [15:0]            stackLo;
    logic [15:0]            stackHi;
    logic [15:0]            psvAddr;
    logic [15:0]            tblAddr;
    logic [NUM_IRQ-1:0][2:0] prio;
    logic [INSTR_W-1:0]     fetchWord;
    logic [PADDR_W-1:0]     progAddr;
    bus_e                   bus;
    logic                   dPhase;
    logic                   aWrite;
    logic                   aOk;
    logic [7:0]             aAddr;
    logic [3:0]             aMask;
    logic                   aTable;
    logic [31:0]            rdata;
  } st_s;

  st_s         st;
  st_s         next_st;
  logic [3:0]  bestLvl;
  logic [5:0]  bestVec;
  logic        excReq;
  logic [15:0] statusView;
  logic [31:0] rdMux;

  // Merges new bus data into an old word by byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  m);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (m[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Shifts left for a positive count, right for a negative one.
  function automatic logic [15:0] shift16(input logic [15:0] v,
                                          input logic [5:0]  sh);
    logic [5:0] mag;
    mag = sh[5] ? 6'(-sh) : sh;
    if (mag > MAX_SHIFT) begin
      return 16'h0000;
    end
    return sh[5] ? (v >> mag) : (v << mag);
  endfunction

  // Status view: repeat flag and the two summary bits are derived.
  always_comb begin
    statusView = st.status;
    statusView[SR_RA] = (st.repCount != 16'h0000);
    statusView[SR_OAB] = st.status[SR_OA] | st.status[SR_OB];
    statusView[SR_SAB] = st.status[SR_SA] | st.status[SR_SB];
  end

  // Exception resolver: highest level wins, lower source wins a tie.
  always_comb begin
    bestLvl = 4'h0;
    bestVec = 6'h00;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irqPend[i] && st.prio[i] != 3'h0 &&
          {1'b0, st.prio[i]} >= bestLvl) begin
        bestLvl = {1'b0, st.prio[i]};
        bestVec = 6'(NUM_TRAPS + i);
      end
    end
    for (int t = 0; t < NUM_TRAPS; t++) begin
      if (trapPend[t] && TRAP_USED[t]) begin
        bestLvl = TRAP_LVL + 4'(t);
        bestVec = 6'(t);
      end
    end
    excReq = bestLvl > {1'b0, st.status[SR_IPL +: 3]};
  end

  // Read multiplexer for the address-phase address.
  always_comb begin
    rdMux = 32'h0000_0000;
    if (haddr[7:0] < A_STATUS) begin
      rdMux = {16'h0000, st.wreg[haddr[5:2]]};
    end else if (haddr[7:0] >= A_PRIO && haddr[7:0] <= A_PRIOEND) begin
      for (int j = 0; j < 8; j++) begin
        if (int'(haddr[4:2]) * 8 + j < NUM_IRQ) begin
          rdMux[j*4 +: 3] = st.prio[int'(haddr[4:2]) * 8 + j];
        end
      end
    end else begin
      case (haddr[7:0])
        A_STATUS:  rdMux = {16'h0000, statusView};
        A_PROGRAM_WINDOW_PAGE:  rdMux = {24'h000000, st.psvPage};
        A_TABLE_ACCESS_PAGE:  rdMux = {24'h000000, st.tblPage};
        A_LSTART:  rdMux = {9'h000, st.loopStart};
        A_LEND:    rdMux = {9'h000, st.loopEnd};
        A_LCOUNT:  rdMux = {16'h0000, st.loopCount};
        A_REPEAT_ITERATION_COUNTER:  rdMux = {16'h0000, st.repCount};
        A_PC:      rdMux = {9'h000, st.pc};
        A_STACKED: rdMux = {st.stackHi, st.stackLo};
        A_EXC:     rdMux = {21'h000000, excReq, bestLvl, bestVec};
        A_FETCH:   rdMux = {8'h00, st.fetchWord};
        A_PSVADDR: rdMux = {16'h0000, st.psvAddr};
        A_TBLADDR: rdMux = {16'h0000, st.tblAddr};
        A_YBASE:   rdMux = {16'h0000, Y_BASE};
        default:   rdMux = 32'h0000_0000;
      endcase
    end
  end

  // Next-state logic: bus slave, register writes and core commands.
  always_comb begin
    logic [31:0] wv;
    logic [3:0]  op;
    logic [3:0]  rs;
    logic [15:0] imm;
    logic [31:0] pv;
    wv = hwdata;
    op = hwdata[3:0];
    rs = hwdata[CMD_REG +: 4];
    imm = hwdata[CMD_IMM +: 16];
    pv = 32'h0000_0000;
    next_st = st;
    // Prefetch latches the word at the program counter a cycle ahead.
    if (st.bus != BUS_WAIT) begin
      next_st.fetchWord = progRdata;
    end
    next_st.progAddr = {1'b0, st.pc};
    // Data phase of a write.
    if (st.dPhase && st.aWrite && st.aOk) begin
      if (st.aAddr < A_STATUS) begin
        pv = merge({16'h0000, st.wreg[st.aAddr[5:2]]}, wv, st.aMask);
        next_st.wreg[st.aAddr[5:2]] = pv[15:0];
      end else if (st.aAddr >= A_PRIO && st.aAddr <= A_PRIOEND) begin
        for (int j = 0; j < 8; j++) begin
          if (int'(st.aAddr[4:2]) * 8 + j < NUM_IRQ) begin
            next_st.prio[int'(st.aAddr[4:2]) * 8 + j] = wv[j*4 +: 3];
          end
        end
      end else begin
        case (st.aAddr)
          A_STATUS: begin
            pv = merge({16'h0000, st.status}, wv, st.aMask);
            next_st.status = (pv[15:0] & ~SR_RO_MASK) |
                             (st.status & SR_RO_MASK);
          end
          A_PROGRAM_WINDOW_PAGE:  next_st.psvPage = wv[7:0];
          A_TABLE_ACCESS_PAGE:  next_st.tblPage = wv[7:0];
          A_LSTART:  next_st.loopStart = wv[PC_W-1:0];
          A_LEND:    next_st.loopEnd = wv[PC_W-1:0];
          A_LCOUNT:  next_st.loopCount = wv[15:0];
          A_REPEAT_ITERATION_COUNTER:  next_st.repCount = wv[15:0];
          A_PC:      next_st.pc = wv[PC_W-1:0];
          A_PSVADDR: next_st.psvAddr = wv[15:0];
          A_TBLADDR: next_st.tblAddr = wv[15:0];
          A_CMD: begin
            case (op)
              OP_PUSHS: begin
                next_st.shW = st.wreg[3:0];
                next_st.shFlags = {st.status[SR_DC], st.status[3:0]};
              end
              OP_POPS: begin
                next_st.wreg[3:0] = st.shW;
                next_st.status[SR_DC] = st.shFlags[4];
                next_st.status[3:0] = st.shFlags[3:0];
              end
              OP_LOOPGO: begin
                next_st.shStart = st.loopStart;
                next_st.shEnd = st.loopEnd;
                next_st.shCount = st.loopCount;
                next_st.shDa = st.status[SR_DA];
                next_st.loopStart = st.pc;
                next_st.loopEnd = st.pc + {6'h00, imm, 1'b0};
                next_st.loopCount = st.wreg[rs];
                next_st.status[SR_DA] = 1'b1;
              end
              OP_LOOPX: begin
                next_st.loopStart = st.shStart;
                next_st.loopEnd = st.shEnd;
                next_st.loopCount = st.shCount;
                next_st.status[SR_DA] = st.shDa;
              end
              OP_EXC: begin
                if (excReq) begin
                  // Loop registers are left alone so loops resume.
                  next_st.stackLo = st.pc[15:0];
                  next_st.stackHi = {st.status[7:0], 1'b0,
                                     st.pc[PC_W-1:16]};
                  next_st.wreg[15] = st.wreg[15] + SP_STEP;
                  next_st.pc = {16'h0000, bestVec, 1'b0};
                  next_st.status[SR_IPL +: 3] =
                    bestLvl[3] ? MAX_IPL : bestLvl[2:0];
                end
              end
              OP_CALL: begin
                next_st.stackLo = st.pc[15:0];
                next_st.stackHi = {8'h00, 1'b0, st.pc[PC_W-1:16]};
                next_st.wreg[15] = st.wreg[15] + SP_STEP;
                next_st.pc = {6'h00, imm, 1'b0};
              end
              OP_RET: begin
                next_st.pc = {st.stackHi[6:0], st.stackLo};
                next_st.wreg[15] = st.wreg[15] - SP_STEP;
                if (imm[0]) begin
                  next_st.status[7:0] = st.stackHi[15:8];
                end
              end
              OP_SHIFT: begin
                next_st.wreg[rs] =
                  shift16(st.wreg[rs], hwdata[CMD_SH +: 6]);
              end
              OP_BYTEWR: begin
                next_st.wreg[rs][7:0] = imm[7:0];
              end
              OP_STEP: begin
                if (st.repCount != 16'h0000) begin
                  next_st.repCount = st.repCount - 16'h0001;
                end else if (st.status[SR_DA] && st.pc == st.loopEnd) begin
                  if (st.loopCount != 16'h0000) begin
                    next_st.loopCount = st.loopCount - 16'h0001;
                    next_st.pc = st.loopStart;
                  end else begin
                    next_st.loopStart = st.shStart;
                    next_st.loopEnd = st.shEnd;
                    next_st.loopCount = st.shCount;
                    next_st.status[SR_DA] = st.shDa;
                    next_st.pc = {st.pc[PC_W-1], st.pc[21:0] + PC_INC};
                  end
                end else begin
                  // The top bit is kept: only specialised paths change it.
                  next_st.pc = {st.pc[PC_W-1], st.pc[21:0] + PC_INC};
                end
              end
              OP_FILEADD: begin
                next_st.wreg[0] = st.wreg[0] + imm;
              end
              OP_ADD3: begin
                next_st.wreg[rs] = st.wreg[imm[3:0]] +
                                   st.wreg[imm[7:4]];
              end
              default: begin
                next_st.pc = st.pc;
              end
            endcase
          end
          default: begin
            next_st.status = st.status;
          end
        endcase
      end
    end
    // Address phase, or completion of a program memory read.
    next_st.dPhase = 1'b0;
    if (hsel && htrans[1] && st.bus != BUS_WAIT) begin
      next_st.dPhase = 1'b1;
      next_st.aWrite = hwrite;
      next_st.aAddr = haddr[7:0];
      next_st.aOk = (haddr[31:8] == 24'h000000);
      next_st.aMask = 4'hF;
      if (hsize == HSIZE_BYTE) begin
        next_st.aMask = 4'h1 << haddr[1:0];
      end else if (hsize == HSIZE_HALF) begin
        next_st.aMask = haddr[1] ? 4'hC : 4'h3;
      end
      next_st.bus = BUS_IDLE;
      next_st.rdata = next_st.aOk ? rdMux : 32'h0000_0000;
      if (!hwrite && next_st.aOk && haddr[7:0] == A_PSVDATA) begin
        next_st.bus = BUS_WAIT;
        next_st.aTable = 1'b0;
        next_st.progAddr = {1'b0, st.psvPage,
                            st.psvAddr[14:0]};
      end else if (!hwrite && next_st.aOk && haddr[7:0] == A_TBLDATA) begin
        next_st.bus = BUS_WAIT;
        next_st.aTable = 1'b1;
        next_st.progAddr = {st.tblPage, st.tblAddr};
      end
    end else if (st.bus == BUS_WAIT) begin
      next_st.bus = BUS_DONE;
      next_st.rdata = st.aTable ? {8'h00, progRdata}
                                : {16'h0000, progRdata[15:0]};
    end else begin
      next_st.bus = BUS_IDLE;
    end
    // Alignment bits are forced on every path.
    next_st.wreg[15][0] = 1'b0;
    next_st.pc[0] = 1'b0;
  end

  // State register with synchronous reset and clock enable.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
      st.wreg[15] <= SP_RESET;
      st.status <= SR_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Outputs.
  assign hrdata     = st.rdata;
  assign hreadyout  = (st.bus != BUS_WAIT);
  assign hresp      = HRESP_OKAY;
  assign progAddr   = st.progAddr;
  assign excRequest = excReq;

endmodule // dsc_core_register_model

/* File: dv/prog_mem_model.sv */
// Program memory model that answers the core's fetch port.
`timescale 1ns/1ns
module prog_mem_model (
  // Fetch port.
  input  wire logic [dsc_core_pkg::PADDR_W-1:0] progAddr,
  output logic      [dsc_core_pkg::INSTR_W-1:0] progRdata
);
  import dsc_core_pkg::*;

  // Each word is a rotation of its address, so no two addresses look alike.
  assign progRdata = {progAddr[7:0], progAddr[23:8]};
endmodule // prog_mem_model

/* File: dv/dsc_core_monitor.sv */
// Port-level checker for the core register model.
`timescale 1ns/1ns
module dsc_core_monitor #(
  parameter int unsigned NUM_IRQ = 54
)(
  // Clock, reset and freeze.
  input wire logic                               clk,
  input wire logic                               rstn,
  input wire logic                               ce,
  // Bus signals.
  input wire logic                               hsel,
  input wire logic [31:0]                        haddr,
  input wire logic [1:0]                         htrans,
  input wire logic                               hwrite,
  input wire logic [2:0]                         hsize,
  input wire logic [31:0]                        hwdata,
  input wire logic [31:0]                        hrdata,
  input wire logic                               hreadyout,
  input wire logic                               hresp,
  // Program memory port.
  input wire logic [dsc_core_pkg::PADDR_W-1:0]   progAddr,
  input wire logic [dsc_core_pkg::INSTR_W-1:0]   progRdata,
  // Exception signals.
  input wire logic [NUM_IRQ-1:0]                 irqPend,
  input wire logic [dsc_core_pkg::NUM_TRAPS-1:0] trapPend,
  input wire logic                               excRequest
);
  import dsc_core_pkg::*;
  logic rd;

  // A read address phase is taken at this edge.
  assign rd = hsel && htrans[1] && !hwrite && hreadyout && ce;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_reset_idle: assert property (disable iff (1'b0)
    !rstn |=> hreadyout && hrdata == 32'h0 && progAddr == 24'h0)
    else $error("outputs not idle after reset");
  a_pc_aligned: assert property (hreadyout |->
    !progAddr[0] && !progAddr[23]) else $error("fetch address misaligned");
  a_pc_read: assert property (rd && haddr == 32'h5C |=>
    hrdata[31:23] == 9'h0 && !hrdata[0]) else $error("pc read wide");
  a_wait_single: assert property (!hreadyout |=> hreadyout)
    else $error("wait lasted over one cycle");
  a_window_low: assert property (rd && haddr == 32'h74 |=>
    !hreadyout ##1 hreadyout && hrdata == {16'h0, $past(progRdata[15:0])})
    else $error("window read wrong");
  a_table_full: assert property (rd && haddr == 32'h7C |=>
    !hreadyout ##1 hreadyout && hrdata == {8'h0, $past(progRdata)})
    else $error("table read wrong");
  a_wreg_width: assert property (rd && haddr[31:6] == 26'h0 |=>
    hreadyout && hrdata[31:16] == 16'h0) else $error("register read wide");
  a_sp_even: assert property (rd && haddr == 32'h3C |=> !hrdata[0])
    else $error("stack pointer odd");
  a_page_width: assert property (rd && haddr == 32'h44 |=>
    hrdata[31:8] == 24'h0) else $error("page read wide");
  a_exc_quiet: assert property (irqPend == '0 &&
    (trapPend & 8'h1E) == 8'h00 |-> !excRequest)
    else $error("exception with nothing pending");
  a_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
endmodule // dsc_core_monitor

bind dsc_core_register_model dsc_core_monitor #(.NUM_IRQ(NUM_IRQ)) u_mon (
  .clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .progAddr(progAddr), .progRdata(progRdata), .irqPend(irqPend),
  .trapPend(trapPend), .excRequest(excRequest));

/* File: dv/dsc_core_register_model_tb.sv */
// Self-checking testbench for the core register model.
`timescale 1ns/1ns
module dsc_core_register_model_tb;
  import dsc_core_pkg::*;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [2:0]  sz;
    logic [31:0] d;
  } row_s;
  localparam logic W = 1'b1;
  localparam logic R = 1'b0;
  localparam logic [2:0] WD = 3'h2;
  localparam int NR = 67;
  // Writes carry data, reads carry the expected value.
  localparam row_s ROWS [NR] = '{
    '{R,8'h3C,WD,32'h800}, '{R,8'h40,WD,32'h0}, '{R,8'h5C,WD,32'h0},
    '{W,8'h3C,WD,32'h1235}, '{R,8'h3C,WD,32'h1234},
    '{W,8'h08,WD,32'hAABE}, '{W,8'h60,WD,32'hEF0029},
    '{R,8'h08,WD,32'hAAEF}, '{W,8'h44,WD,32'h5A}, '{R,8'h44,WD,32'h5A},
    '{W,8'h40,WD,32'hFFFF}, '{R,8'h40,WD,32'hFDEF}, '{W,8'h40,WD,32'h0},
    '{W,8'hA0,WD,32'h1234}, '{R,8'hA0,WD,32'h0},
    '{W,8'h5C,WD,32'hFFFFFF}, '{R,8'h5C,WD,32'h7FFFFE},
    '{W,8'h04,WD,32'h3}, '{W,8'h60,WD,32'h418}, '{R,8'h04,WD,32'h30},
    '{W,8'h60,WD,32'h3C18}, '{R,8'h04,WD,32'h3},
    '{W,8'h00,WD,32'h5}, '{W,8'h60,WD,32'h3000B}, '{R,8'h00,WD,32'h8},
    '{W,8'h60,WD,32'h21004C}, '{R,8'h10,WD,32'hAAF2},
    '{W,8'h60,WD,32'h1}, '{W,8'h00,WD,32'h0}, '{W,8'h60,WD,32'h2},
    '{R,8'h00,WD,32'h8}, '{W,8'h5C,WD,32'h100}, '{W,8'h60,WD,32'h400006},
    '{R,8'h3C,WD,32'h1238}, '{R,8'h5C,WD,32'h80}, '{W,8'h60,WD,32'h7},
    '{R,8'h5C,WD,32'h100}, '{R,8'h3C,WD,32'h1234},
    '{W,8'h70,WD,32'h1234}, '{R,8'h74,WD,32'h2D12},
    '{W,8'h48,WD,32'h12}, '{W,8'h78,WD,32'hABCD}, '{R,8'h7C,WD,32'hCD12AB},
    '{W,8'h0C,WD,32'h1}, '{W,8'h58,WD,32'h1}, '{R,8'h40,WD,32'h10},
    '{W,8'h60,WD,32'hA}, '{W,8'h60,WD,32'hA}, '{R,8'h5C,WD,32'h102},
    '{W,8'h60,WD,32'h10033}, '{R,8'h50,WD,32'h104}, '{R,8'h40,WD,32'h200},
    '{W,8'h60,WD,32'h4}, '{R,8'h50,WD,32'h0}, '{W,8'h60,WD,32'h10033},
    '{W,8'h60,WD,32'hA}, '{W,8'h60,WD,32'hA}, '{R,8'h5C,WD,32'h102},
    '{W,8'h60,WD,32'hA}, '{W,8'h60,WD,32'hA}, '{R,8'h40,WD,32'h0},
    '{R,8'h5C,WD,32'h106}, '{R,8'h6C,WD,32'h60001}, '{W,8'h9C,WD,32'hFFFF},
    '{R,8'h9C,WD,32'hC00}, '{W,8'h54,WD,32'h7}, '{W,8'h5C,WD,32'h100}
  };
  logic        clk;
  logic        rstn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [23:0] progAddr;
  logic [23:0] progRdata;
  logic [53:0] irqPend;
  logic [7:0]  trapPend;
  logic        excRequest;
  logic [31:0] r;
  int          errors;
  int          checked;
  int          cycles = 0;

  dsc_core_register_model u_dut (.clk(clk), .rstn(rstn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .progAddr(progAddr),
    .progRdata(progRdata), .irqPend(irqPend), .trapPend(trapPend),
    .excRequest(excRequest));
  prog_mem_model u_mem (.progAddr(progAddr), .progRdata(progRdata));

  // Clock at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops.
  task conclude();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Counts a comparison and reports a mismatch.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single bus transfer; entered just after a rising edge.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [2:0] sz, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= sz;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // Cuts a hang short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  // Main sequence.
  initial begin
    {rstn, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    {irqPend, trapPend, errors, checked} = '0;
    ce = 1'b1;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < NR; i++) begin
      ahb(ROWS[i].w, ROWS[i].a, ROWS[i].sz, ROWS[i].d, r);
      if (!ROWS[i].w && i < 9)
        chk(r, ROWS[i].d);
      else if (!ROWS[i].w && i < 30)
        chk(r, ROWS[i].d);
      else if (!ROWS[i].w && i < 43)
        chk(r, ROWS[i].d);
      else if (!ROWS[i].w)
        chk(r, ROWS[i].d);
    end
    $display("test register rows done");
    trapPend <= 8'h01;
    irqPend <= 54'hA;
    repeat (2) @(posedge clk);
    chk({31'h0, excRequest}, 32'h0);
    ahb(W, A_PRIO, WD, 32'h5050, r);
    @(posedge clk);
    chk({31'h0, excRequest}, 32'h1);
    ahb(R, A_EXC, WD, 32'h0, r);
    chk(r, 32'h549);
    ahb(W, A_STATUS, WD, 32'hA0, r);
    @(posedge clk);
    chk({31'h0, excRequest}, 32'h0);
    trapPend <= 8'h03;
    repeat (2) @(posedge clk);
    chk({31'h0, excRequest}, 32'h1);
    ahb(W, A_CMD, WD, 32'h5, r);
    ahb(R, A_STACKED, WD, 32'h0, r);
    chk(r, 32'hA0000100);
    ahb(R, A_PC, WD, 32'h0, r);
    chk(r, 32'h2);
    ahb(R, 8'h3C, WD, 32'h0, r);
    chk(r, 32'h1238);
    ahb(R, A_LCOUNT, WD, 32'h0, r);
    chk(r, 32'h7);
    ahb(R, A_STATUS, WD, 32'h0, r);
    chk(r, 32'hE0);
    $display("test exceptions done");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    ahb(R, 8'h3C, WD, 32'h0, r);
    chk(r, 32'h800);
    ahb(R, A_STATUS, WD, 32'h0, r);
    chk(r, 32'h0);
    $display("test second reset done");
    conclude();
  end
endmodule // dsc_core_register_model_tb
